// file: ffr_fuse_readout.sv
`timescale 1ns/10ps
// Function
// - Lock status bit 1 means region locked
// - High word at 0x0C holds fuses 32..63
// - Low word at 0x10 holds fuses 0..31
// - Fuse reads 0 programmed, 1 erased
// - Chip erase sets all fuses to ones
// - Low word: locks, fetch lock, boot protect
// - Brown-out enable code decode
// - Hysteresis fuse 1 enables hysteresis
// - Level above core supply holds reset while brown-out detector enabled
// - External fetch lock has no effect
// - Shipped low word is 0xFC07FFFF
// - Boot protect 011b gives 8 Ko
// - Lock fuse at 1 leaves region unlocked
// - Fuses 29..31 shipped at one
// - Bootloader word at 0x808001FC, 0x929E0D6B
// - 120-bit serial number readable
// - Fuse bits changed only by commands 7, 8, chip erase and reset, which reloads the shipped words
module ffr_fuse_readout #(
    parameter int               HIGH_FUSES  = 0,
    parameter logic [119:0]     SERIAL_NUM  = 120'h0,
    parameter logic [5:0]       BOD_LEVEL_MAX_SAFE = 6'h3f
) (
    input  wire logic                   clk_sys,
    input  wire logic                   reset_n,
    input  wire logic                   clk_en,
    input  wire ffr_pkg::ffr_avmm_req_t avs_req,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    input  wire logic                   chip_erase_pin,
    output ffr_pkg::ffr_decoded_t       fuse_decoded,
    output logic                        brownout_hold_reset
);
    import ffr_pkg::*;

    // ------------------------------------------------------------
    // Fuse storage
    // ------------------------------------------------------------
    logic [31:0] fuse_low;
    logic [31:0] fuse_high;
    logic [31:0] boot_cfg;
    logic [1:0]  erase_sync;
    logic        erase_prev;
    logic        erase_pulse;
    logic        acc_done;
    logic        cmd_ok;
    logic [5:0]  cmd_index;
    logic        cmd_prog;
    logic        cmd_erase;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            erase_sync <= 2'h0;
            erase_prev <= 1'b0;
        end else if (clk_en) begin
            erase_sync <= {erase_sync[0], chip_erase_pin};
            erase_prev <= erase_sync[1];
        end
    end
    assign erase_pulse = erase_sync[1] & ~erase_prev;

    assign cmd_ok    = avs_req.write && !avs_waitrequest && avs_req.address == ADDR_FUSE_CMD
                       && avs_req.writedata[31:24] == CMD_KEY;
    assign cmd_index = avs_req.writedata[13:8];
    assign cmd_prog  = cmd_ok && avs_req.writedata[3:0] == CMD_FUSE_PROGRAM;
    assign cmd_erase = cmd_ok && avs_req.writedata[3:0] == CMD_FUSE_ERASE;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fuse_low  <= FUSE_LOW_SHIPPED;
            fuse_high <= FUSE_ERASED;
        end else if (clk_en) begin
            if (erase_pulse) begin
                fuse_low  <= FUSE_ERASED;
                fuse_high <= FUSE_ERASED;
            end else if (cmd_prog) begin
                if (cmd_index[5])
                    fuse_high[cmd_index[4:0]] <= 1'b0;
                else
                    fuse_low[cmd_index[4:0]] <= 1'b0;
            end else if (cmd_erase) begin
                if (cmd_index[5])
                    fuse_high[cmd_index[4:0]] <= 1'b1;
                else
                    fuse_low[cmd_index[4:0]] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            boot_cfg <= BOOT_CFG_DEFAULT;
        end else if (clk_en) begin
            if (avs_req.write && !avs_waitrequest && avs_req.address == ADDR_BOOT_CFG)
                boot_cfg <= avs_req.writedata;
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    ffr_decoded_t next_decoded;
    logic [1:0]   bod_code;
    logic [5:0]   bod_level;
    logic [2:0]   boot_prot;

    always_comb begin
        bod_code  = fuse_low[POS_BOD_EN +: 2];
        bod_level = fuse_low[POS_BOD_LEVEL +: 6];
        boot_prot = fuse_low[POS_BOOT_PROT +: 3];
        next_decoded = '0;
        for (int i = 0; i < 16; i++)
            next_decoded.region_lock_flag[i] = ~fuse_low[POS_LOCK + i];
        next_decoded.bod_enabled = (bod_code == BOD_EN_RESET)
                                   || (bod_code == BOD_EN_NO_RESET);
        next_decoded.bod_reset_enabled = (bod_code == BOD_EN_RESET);
        next_decoded.brownout_hysteresis = fuse_low[POS_BOD_HYST];
        next_decoded.hold_in_reset = next_decoded.bod_enabled
                                     && bod_level > BOD_LEVEL_MAX_SAFE;
        next_decoded.boot_protect_kb = (boot_prot == BOOT_PROT_8K) ? BOOT_PROT_8K_KB
                                       : 8'h00;
        // Fetch lock bit is kept in the word but steers nothing
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fuse_decoded        <= '0;
            brownout_hold_reset <= 1'b0;
        end else if (clk_en) begin
            fuse_decoded        <= next_decoded;
            brownout_hold_reset <= next_decoded.hold_in_reset;
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM slave, one wait cycle per access
    // ------------------------------------------------------------
    logic [31:0] next_readdata;
    logic [31:0] high_mask;

    always_comb begin
        high_mask = (HIGH_FUSES > 0) ? 32'hffffffff : 32'h0;
        next_readdata = 32'h0;
        case (avs_req.address)
            ADDR_FUSE_HIGH:   next_readdata = fuse_high & high_mask;
            ADDR_FUSE_LOW:    next_readdata = fuse_low;
            ADDR_LOCK_STATUS: next_readdata = {16'h0, next_decoded.region_lock_flag};
            ADDR_DECODED:     next_readdata = {20'h0, next_decoded.boot_protect_kb,
                                               next_decoded.hold_in_reset,
                                               next_decoded.brownout_hysteresis,
                                               next_decoded.bod_reset_enabled,
                                               next_decoded.bod_enabled};
            ADDR_BOOT_CFG:    next_readdata = boot_cfg;
            ADDR_SERIAL0:     next_readdata = SERIAL_NUM[31:0];
            ADDR_SERIAL0 + 8'h04: next_readdata = SERIAL_NUM[63:32];
            ADDR_SERIAL0 + 8'h08: next_readdata = SERIAL_NUM[95:64];
            ADDR_SERIAL3:     next_readdata = {8'h0, SERIAL_NUM[119:96]};
            default:          next_readdata = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
            acc_done        <= 1'b0;
            avs_readdata    <= 32'h0;
        end else if (clk_en) begin
            if ((avs_req.read || avs_req.write) && !acc_done && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                acc_done        <= 1'b1;
                avs_readdata    <= avs_req.read ? next_readdata : 32'h0;
            end else begin
                avs_waitrequest <= 1'b1;
                acc_done        <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_fuse_word_write_ignored: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && avs_req.write && !avs_waitrequest && !cmd_ok && !erase_pulse)
        |=> (fuse_low == $past(fuse_low)))
        else $error("fuse word changed by a plain write");
    a_erase_sets_ones: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && erase_pulse) |=> (fuse_low == FUSE_ERASED && fuse_high == FUSE_ERASED))
        else $error("chip erase left a programmed fuse");
    a_program_clears_bit: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && cmd_prog && !erase_pulse && !cmd_index[5])
        |=> fuse_low[$past(cmd_index[4:0])] == 1'b0)
        else $error("fuse program command did not program");
    a_erase_cmd_sets_bit: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && cmd_erase && !erase_pulse && !cmd_index[5])
        |=> fuse_low[$past(cmd_index[4:0])] == 1'b1)
        else $error("fuse erase command did not erase");
    a_lock_flag_inverts: assert property (@(posedge clk_sys) disable iff (!reset_n)
        next_decoded.region_lock_flag == ~fuse_low[15:0])
        else $error("lock status does not mirror lock fuses");
    a_bod_decode: assert property (@(posedge clk_sys) disable iff (!reset_n)
        next_decoded.bod_enabled == (fuse_low[28:27] == 2'h1 || fuse_low[28:27] == 2'h2))
        else $error("brown-out enable decode wrong");
    a_hold_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && next_decoded.hold_in_reset) |=> brownout_hold_reset)
        else $error("reset hold not raised");
    a_read_low_word: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && avs_req.read && avs_waitrequest && !acc_done
         && avs_req.address == ADDR_FUSE_LOW) |=> (!avs_waitrequest && avs_readdata == $past(fuse_low)))
        else $error("low fuse word read wrong");
    a_boot_prot_size: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (fuse_low[19:17] == 3'h3) |-> next_decoded.boot_protect_kb == 8'h08)
        else $error("boot protect size wrong");

    // ------------------------------------------------------------
    // Clock enable and bus handshake checks
    // ------------------------------------------------------------
    a_freeze_fuses: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !clk_en |=> (fuse_low == $past(fuse_low) && fuse_high == $past(fuse_high)))
        else $error("fuse state moved while clock enable low");
    a_freeze_bus: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !clk_en |=> (avs_waitrequest == $past(avs_waitrequest) && avs_readdata == $past(avs_readdata)))
        else $error("bus outputs moved while clock enable low");
    a_freeze_decoded: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !clk_en |=> (fuse_decoded == $past(fuse_decoded)))
        else $error("decoded fields moved while clock enable low");
    a_wait_one_cycle: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && !avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_idle_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && !avs_req.read && !avs_req.write) |=> avs_waitrequest)
        else $error("waitrequest dropped without a request");
    a_answer_next: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && (avs_req.read || avs_req.write) && avs_waitrequest && !acc_done)
        |=> !avs_waitrequest)
        else $error("access not answered after one wait cycle");
    a_readdata_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(clk_en && (avs_req.read || avs_req.write) && avs_waitrequest && !acc_done)
        |=> (avs_readdata == $past(avs_readdata)))
        else $error("read data changed outside an access");
    a_acc_done_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
        acc_done == !avs_waitrequest)
        else $error("access tracker out of step with waitrequest");
    a_write_zero_data: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && avs_req.write && !avs_req.read && avs_waitrequest && !acc_done)
        |=> (avs_readdata == 32'h0))
        else $error("write left stale read data");

    // ------------------------------------------------------------
    // Register read checks
    // ------------------------------------------------------------
    a_read_high_word: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && avs_req.read && avs_waitrequest && !acc_done
         && avs_req.address == ADDR_FUSE_HIGH) |=> (avs_readdata == ($past(fuse_high) & high_mask)))
        else $error("high fuse word read wrong");
    a_read_lock_status: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && avs_req.read && avs_waitrequest && !acc_done
         && avs_req.address == ADDR_LOCK_STATUS) |=> (avs_readdata == {16'h0, ~$past(fuse_low[15:0])}))
        else $error("lock status read wrong");
    a_read_decoded: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && avs_req.read && avs_waitrequest && !acc_done
         && avs_req.address == ADDR_DECODED) |=> (avs_readdata[31:12] == 20'h0))
        else $error("decoded register upper bits not zero");
    a_read_boot_cfg: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && avs_req.read && avs_waitrequest && !acc_done
         && avs_req.address == ADDR_BOOT_CFG) |=> (avs_readdata == $past(boot_cfg)))
        else $error("bootloader word read wrong");
    a_read_serial_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && avs_req.read && avs_waitrequest && !acc_done
         && avs_req.address == ADDR_SERIAL0) |=> (avs_readdata == SERIAL_NUM[31:0]))
        else $error("serial word 0 read wrong");
    a_read_serial_one: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && avs_req.read && avs_waitrequest && !acc_done
         && avs_req.address == ADDR_SERIAL0 + 8'h04) |=> (avs_readdata == SERIAL_NUM[63:32]))
        else $error("serial word 1 read wrong");
    a_read_serial_two: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && avs_req.read && avs_waitrequest && !acc_done
         && avs_req.address == ADDR_SERIAL0 + 8'h08) |=> (avs_readdata == SERIAL_NUM[95:64]))
        else $error("serial word 2 read wrong");
    a_read_serial_top: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && avs_req.read && avs_waitrequest && !acc_done
         && avs_req.address == ADDR_SERIAL3) |=> (avs_readdata == {8'h0, SERIAL_NUM[119:96]}))
        else $error("serial word 3 read wrong");
    a_read_unmapped: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && avs_req.read && avs_waitrequest && !acc_done
         && avs_req.address > ADDR_SERIAL3) |=> (avs_readdata == 32'h0))
        else $error("unmapped read not zero");

    // ------------------------------------------------------------
    // Fuse and bootloader word update checks
    // ------------------------------------------------------------
    a_high_write_ignored: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && avs_req.write && !avs_waitrequest && !cmd_ok && !erase_pulse)
        |=> (fuse_high == $past(fuse_high)))
        else $error("high fuse word changed by a plain write");
    a_bad_key_ignored: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && avs_req.write && !avs_waitrequest && avs_req.address == ADDR_FUSE_CMD
         && avs_req.writedata[31:24] != CMD_KEY && !erase_pulse)
        |=> (fuse_low == $past(fuse_low) && fuse_high == $past(fuse_high)))
        else $error("command with wrong key changed a fuse");
    a_fuses_cmd_only: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && !cmd_prog && !cmd_erase && !erase_pulse)
        |=> (fuse_low == $past(fuse_low) && fuse_high == $past(fuse_high)))
        else $error("fuse changed without a command");
    a_high_program_bit: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && cmd_prog && !erase_pulse && cmd_index[5])
        |=> fuse_high[$past(cmd_index[4:0])] == 1'b0)
        else $error("high fuse program command did not program");
    a_high_erase_bit: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && cmd_erase && !erase_pulse && cmd_index[5])
        |=> fuse_high[$past(cmd_index[4:0])] == 1'b1)
        else $error("high fuse erase command did not erase");
    a_erase_pulse_once: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && erase_pulse) |=> !erase_pulse)
        else $error("chip erase pulse longer than one cycle");
    a_boot_cfg_write_only: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(clk_en && avs_req.write && !avs_waitrequest && avs_req.address == ADDR_BOOT_CFG)
        |=> (boot_cfg == $past(boot_cfg)))
        else $error("bootloader word changed without a write");

    // ------------------------------------------------------------
    // Decode checks
    // ------------------------------------------------------------
    a_decoded_follows: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en |=> (fuse_decoded == $past(next_decoded)))
        else $error("decoded fields not registered");
    a_lock_flag_reg: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en |=> (fuse_decoded.region_lock_flag == ~$past(fuse_low[15:0])))
        else $error("registered lock flags wrong");
    a_hold_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && !next_decoded.hold_in_reset) |=> !brownout_hold_reset)
        else $error("reset hold raised without cause");
    a_hold_needs_bod: assert property (@(posedge clk_sys) disable iff (!reset_n)
        brownout_hold_reset |-> fuse_decoded.bod_enabled)
        else $error("reset hold with detector disabled");
    a_reset_needs_en: assert property (@(posedge clk_sys) disable iff (!reset_n)
        fuse_decoded.bod_reset_enabled |-> fuse_decoded.bod_enabled)
        else $error("detector reset without detector enabled");
    a_bod_off_codes: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (fuse_low[28:27] == 2'h0 || fuse_low[28:27] == 2'h3) |-> !next_decoded.bod_enabled)
        else $error("detector enabled by a disabling code");
    a_hyst_follows: assert property (@(posedge clk_sys) disable iff (!reset_n)
        next_decoded.brownout_hysteresis == fuse_low[26])
        else $error("hysteresis does not follow its fuse");
    a_boot_prot_other: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (fuse_low[19:17] != 3'h3) |-> next_decoded.boot_protect_kb == 8'h00)
        else $error("boot protect size for undecoded code");
endmodule

// file: ffr_fuse_readout_tb.sv
`timescale 1ns/10ps
module ffr_fuse_readout_tb;
    import ffr_pkg::*;
    localparam logic [119:0] SN   = 120'h0123456789abcdef0123456789abcd;
    localparam logic [5:0]   SAFE = 6'h10;
    logic                    clk_sys, reset_n, clk_en, chip_erase_pin;
    logic                    avs_waitrequest, brownout_hold_reset;
    logic [31:0]             avs_readdata, rd, fuse_lo, fuse_hi;
    ffr_avmm_req_t           avs_req;
    ffr_decoded_t            fuse_decoded;
    int                      n_errors, checked, i;

    always #5 clk_sys = ~clk_sys;

    ffr_fuse_readout #(.HIGH_FUSES(32), .SERIAL_NUM(SN), .BOD_LEVEL_MAX_SAFE(SAFE))
    i_ffr_fuse_readout (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
        .avs_req(avs_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .chip_erase_pin(chip_erase_pin), .fuse_decoded(fuse_decoded),
        .brownout_hold_reset(brownout_hold_reset));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("errors %0d checked %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic ffr_decoded_t expect_dec(input logic [31:0] w);
        ffr_decoded_t e;
        e.region_lock_flag    = ~w[15:0];
        e.bod_enabled         = (w[28:27] == BOD_EN_RESET) || (w[28:27] == BOD_EN_NO_RESET);
        e.bod_reset_enabled   = (w[28:27] == BOD_EN_RESET);
        e.brownout_hysteresis = w[26];
        e.hold_in_reset       = e.bod_enabled && (w[25:20] > SAFE);
        e.boot_protect_kb     = (w[19:17] == BOOT_PROT_8K) ? BOOT_PROT_8K_KB : 8'h00;
        return e;
    endfunction

    task automatic chk_dec;
        ffr_decoded_t e;
        e = expect_dec(fuse_lo);
        repeat (3) @(posedge clk_sys);
        checked++;
        if (fuse_decoded !== e || brownout_hold_reset !== e.hold_in_reset) begin
            n_errors++;
            $display("MISMATCH %0t decoded %h exp %h", $time, fuse_decoded, e);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        avs_req.read      <= ~wr;
        avs_req.write     <= wr;
        avs_req.address   <= a;
        avs_req.writedata <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            n_errors++;
            $display("MISMATCH %0t bus timeout", $time);
            end_of_test();
        end
        rd = avs_readdata;
        avs_req.read  <= 1'b0;
        avs_req.write <= 1'b0;
    endtask

    task automatic fuse_cmd(input logic [3:0] c, input logic [5:0] idx, input logic [7:0] key);
        bus(1'b1, ADDR_FUSE_CMD, {key, 10'h000, idx, 4'h0, c});
        if (key == CMD_KEY && (c == CMD_FUSE_PROGRAM || c == CMD_FUSE_ERASE)) begin
            if (idx[5]) begin
                fuse_hi[idx[4:0]] = (c == CMD_FUSE_ERASE);
            end else begin
                fuse_lo[idx[4:0]] = (c == CMD_FUSE_ERASE);
            end
        end
    endtask

    task automatic check_words;
        bus(1'b0, ADDR_FUSE_LOW, 32'h0);
        chk_word(rd, fuse_lo, "low word");
        bus(1'b0, ADDR_FUSE_HIGH, 32'h0);
        chk_word(rd, fuse_hi, "high word");
        bus(1'b0, ADDR_LOCK_STATUS, 32'h0);
        chk_word(rd, {16'h0, ~fuse_lo[15:0]}, "lock status");
        chk_dec();
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys        = 1'b0;
        reset_n        = 1'b0;
        clk_en         = 1'b1;
        chip_erase_pin = 1'b0;
        avs_req        = '0;
        n_errors       = 0;
        checked        = 0;
        fuse_lo        = FUSE_LOW_SHIPPED;
        fuse_hi        = FUSE_ERASED;
        void'($urandom(41114));
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        check_words();
        bus(1'b0, ADDR_BOOT_CFG, 32'h0);
        chk_word(rd, BOOT_CFG_DEFAULT, "boot cfg");
        for (i = 0; i < 4; i++) begin
            bus(1'b0, ADDR_SERIAL0 + 8'(4 * i), 32'h0);
            chk_word(rd, 32'({8'h00, SN} >> (32 * i)), "serial");
        end
        bus(1'b0, 8'h30, 32'h0);
        chk_word(rd, 32'h0, "unmapped");
        bus(1'b1, ADDR_FUSE_LOW, $urandom());
        bus(1'b1, ADDR_FUSE_HIGH, $urandom());
        check_words();
        for (i = 0; i < 4; i++) begin
            fuse_cmd(i[0] ? CMD_FUSE_ERASE : CMD_FUSE_PROGRAM, 6'd27, CMD_KEY);
            fuse_cmd(i[1] ? CMD_FUSE_ERASE : CMD_FUSE_PROGRAM, 6'd28, CMD_KEY);
            chk_dec();
        end
        fuse_cmd(CMD_FUSE_PROGRAM, 6'd26, CMD_KEY);
        chk_dec();
        fuse_cmd(CMD_FUSE_ERASE, 6'd26, CMD_KEY);
        fuse_cmd(CMD_FUSE_PROGRAM, 6'd28, CMD_KEY);
        for (i = 20; i < 26; i++) fuse_cmd(CMD_FUSE_ERASE, 6'(i), CMD_KEY);
        chk_dec();
        fuse_cmd(CMD_FUSE_ERASE, 6'd28, CMD_KEY);
        chk_dec();
        fuse_cmd(CMD_FUSE_PROGRAM, 6'd3, 8'h5a);
        check_words();
        repeat (40) begin
            fuse_cmd($urandom_range(1) ? CMD_FUSE_ERASE : CMD_FUSE_PROGRAM, 6'($urandom), CMD_KEY);
            check_words();
        end
        fuse_cmd(CMD_FUSE_PROGRAM, 6'd19, CMD_KEY);
        fuse_cmd(CMD_FUSE_ERASE, 6'd18, CMD_KEY);
        fuse_cmd(CMD_FUSE_ERASE, 6'd17, CMD_KEY);
        chk_dec();
        clk_en <= 1'b0;
        repeat (6) @(posedge clk_sys);
        clk_en <= 1'b1;
        check_words();
        chip_erase_pin <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chip_erase_pin <= 1'b0;
        fuse_lo = FUSE_ERASED;
        fuse_hi = FUSE_ERASED;
        check_words();
        end_of_test();
    end
endmodule

// file: ffr_pkg.sv
package ffr_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_FUSE_HIGH    = 8'h0c;
    localparam logic [7:0]  ADDR_FUSE_LOW     = 8'h10;
    localparam logic [7:0]  ADDR_FUSE_CMD     = 8'h00;
    localparam logic [7:0]  ADDR_LOCK_STATUS  = 8'h04;
    localparam logic [7:0]  ADDR_DECODED      = 8'h08;
    localparam logic [7:0]  ADDR_BOOT_CFG     = 8'h14;
    localparam logic [7:0]  ADDR_SERIAL0      = 8'h18;
    localparam logic [7:0]  ADDR_SERIAL3      = 8'h24;
    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [31:0] FUSE_LOW_SHIPPED  = 32'hfc07ffff;
    localparam logic [31:0] FUSE_ERASED       = 32'hffffffff;
    localparam logic [31:0] BOOT_CFG_DEFAULT  = 32'h929e0d6b;
    localparam logic [31:0] BOOT_CFG_ADDR     = 32'h808001fc;
    localparam logic [31:0] SERIAL_ADDR_FIRST = 32'h80800204;
    localparam logic [31:0] SERIAL_ADDR_LAST  = 32'h80800212;
    localparam int          SERIAL_BITS       = 120;
    localparam int          FUSE_COUNT        = 32;
    localparam logic [3:0]  CMD_FUSE_PROGRAM  = 4'h7;
    localparam logic [3:0]  CMD_FUSE_ERASE    = 4'h8;
    localparam logic [7:0]  CMD_KEY           = 8'ha5;
    // ------------------------------------------------------------
    // Field positions in the low fuse word
    // ------------------------------------------------------------
    localparam int          POS_LOCK          = 0;
    localparam int          POS_EXT_FETCH     = 16;
    localparam int          POS_BOOT_PROT     = 17;
    localparam int          POS_BOD_LEVEL     = 20;
    localparam int          POS_BOD_HYST      = 26;
    localparam int          POS_BOD_EN        = 27;
    localparam logic [1:0]  BOD_EN_RESET      = 2'h1;
    localparam logic [1:0]  BOD_EN_NO_RESET   = 2'h2;
    localparam logic [2:0]  BOOT_PROT_8K      = 3'h3;
    localparam logic [7:0]  BOOT_PROT_8K_KB   = 8'h08;

    typedef struct packed {
        logic [15:0] region_lock_flag;
        logic        bod_enabled;
        logic        bod_reset_enabled;
        logic        brownout_hysteresis;
        logic        hold_in_reset;
        logic [7:0]  boot_protect_kb;
    } ffr_decoded_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } ffr_avmm_req_t;
endpackage
